// >>> verilog/dps_pkg.sv
/*
 * shared constants and types of the dual protocol serial target and its host end.
 * assumes a single 200 MHz reference clock at both ends.
 */
package dps_pkg;
	localparam int          REF_CLK_NS   = 5;
	localparam int          AW           = 7;
	localparam int          DW           = 16;
	localparam int          FRAME_BITS   = 24;
	localparam int          OP_BIT       = 23;
	localparam int          ADDR_HI      = 22;
	localparam int          ADDR_LO      = 16;
	localparam int          DATA_HI      = 15;
	localparam int          BYTE_MSB     = 7;
	localparam logic [4:0]  FRAME_LAST   = 5'h17;
	localparam logic [0:0]  OP_READ      = 1'h1;
	localparam logic [7:0]  GC_ADDR      = 8'h00;
	localparam logic [7:0]  GC_RESET     = 8'h06;
	localparam logic [3:0]  ACK_BIT      = 4'h8;
	localparam logic [1:0]  IDX_CMD      = 2'h0;
	localparam logic [1:0]  IDX_MSB      = 2'h1;
	localparam logic [1:0]  IDX_LSB      = 2'h2;
	// synchronised pin vector layout
	localparam int          P_SYNC       = 4;
	localparam int          P_SCLK       = 3;
	localparam int          P_SDI        = 2;
	localparam int          P_SCL        = 1;
	localparam int          P_SDA        = 0;
	localparam int          NPINS        = 5;
	// host timing
	localparam int          SCLK_PERIOD_NS = 125;
	localparam int          SCLK_HALF      = SCLK_PERIOD_NS / 2 / REF_CLK_NS;
	localparam int          I2C_BIT_NS     = 1000;
	localparam int          I2C_QUARTER    = I2C_BIT_NS / 4 / REF_CLK_NS;

	typedef enum logic [1:0] {DPS_NONE, DPS_SPI, DPS_I2C} dps_proto_t;
	typedef enum logic [1:0] {DPS_START, DPS_STOP, DPS_WRITE, DPS_READ} dps_icmd_t;
endpackage

// >>> verilog/dps_if.sv
/*
 * pins between the host end and the target end.
 * resolves open-drain and tristate pins from enables; idle lines pull high.
 */
`timescale 1ns/1ps
interface dps_if;
	logic sync_n;
	logic sclk;
	logic sdi;
	logic sdo_o;
	logic sdo_oe_n;
	logic scl_o;
	logic scl_oe_n;
	logic h_sda_o;
	logic h_sda_oe_n;
	logic t_sda_o;
	logic t_sda_oe_n;
	logic sdo;
	logic scl;
	logic sda;

	assign sdo = sdo_oe_n | sdo_o;
	assign scl = scl_oe_n | scl_o;
	assign sda = (h_sda_oe_n | h_sda_o) & (t_sda_oe_n | t_sda_o);

	modport target (input sync_n, sclk, sdi, scl, sda,
		output sdo_o, sdo_oe_n, t_sda_o, t_sda_oe_n);
	modport host (output sync_n, sclk, sdi, scl_o, scl_oe_n, h_sda_o, h_sda_oe_n,
		input sdo, scl, sda);
endinterface

// >>> verilog/dps_sync.sv
/*
 * two flip-flop synchroniser for a vector of independent levels.
 * assumes each bit is a slow level, never a multi-bit word.
 */
`timescale 1ns/1ps
module dps_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// >>> verilog/dps_target.sv
/*
 * target end: spi frame receiver and i2c target feeding a 7-bit by 16-bit register port.
 * assumes the register store answers RD_DATA combinationally for RD_ADDR on REF_CLK.
 */
// Functional notes
// - sample sdi on sclk falls while selected
// - host holds select for 24 falls
// - drop accesses shorter than one frame
// - three-wire mode keeps first 24 bits
// - deselected: ignore inputs, release sdo
// - bit 23 chooses write or read
// - bits 22 to 16 give address
// - write data_field; ignore it on reads
// - host enables serial out before reads
// - host sends another frame for read data
// - next frame echoes op, address, read data
// - sdo launches on edge per select
// - daisy chain keeps last 24 bits
// - four-wire drops non-multiple edge counts
// - only seven-bit i2c addressing
// - same logic at all i2c rates
// - general call 06 resets at ack rise
// - ninth clock low means acknowledge
// - start is sda fall with scl high
// - acknowledge address only on match
// - receiver acknowledges every data byte
// - stop releases bus, wait for start
// - first protocol heard is locked
`timescale 1ns/1ps
module dps_target (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST_N,
	dps_if.target                     PINS,
	input  wire logic [dps_pkg::AW-1:0] OWN_ADDR,
	input  wire logic                 SERIAL_OUT_ENABLE,
	input  wire logic                 SERIAL_OUT_EDGE_SELECT,
	output logic                      WR_STB,
	output logic [dps_pkg::AW-1:0]    WR_ADDR,
	output logic [dps_pkg::DW-1:0]    WR_DATA,
	output logic [dps_pkg::AW-1:0]    RD_ADDR,
	input  wire logic [dps_pkg::DW-1:0] RD_DATA,
	output logic                      SOFT_RESET,
	output dps_pkg::dps_proto_t       PROTOCOL
);
	import dps_pkg::*;

	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} dps_ist_t;

	// ----------------------------------------------------------------
	// pin sampling and edges
	// ----------------------------------------------------------------
	logic [NPINS-1:0] pin_s;
	logic [NPINS-1:0] prev_q;
	logic [NPINS-1:0] fall;
	logic [NPINS-1:0] rise;
	logic             start_c;
	logic             stop_c;

	dps_sync #(.W(NPINS)) u_sync (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.d     ({PINS.sync_n, PINS.sclk, PINS.sdi, PINS.scl, PINS.sda}),
		.q     (pin_s)
	);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			prev_q <= '1;
		else
			prev_q <= pin_s;
	end

	assign fall    = prev_q & ~pin_s;
	assign rise    = ~prev_q & pin_s;
	assign start_c = fall[P_SDA] & pin_s[P_SCL] & prev_q[P_SCL];
	assign stop_c  = rise[P_SDA] & pin_s[P_SCL] & prev_q[P_SCL];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dps_proto_t              proto_q, proto_d;
	logic [FRAME_BITS-1:0]   shift_q, shift_d;
	logic [FRAME_BITS-1:0]   first_q, first_d;
	logic [FRAME_BITS-1:0]   last_q, last_d;
	logic [4:0]              mod_q, mod_d;
	logic                    full_q, full_d;
	logic                    sdo_q, sdo_d;
	logic                    wr_q, wr_d;
	logic [AW-1:0]           wa_q, wa_d;
	logic [DW-1:0]           wd_q, wd_d;
	logic                    rst_q, rst_d;
	dps_ist_t                ist_q, ist_d;
	logic [3:0]              bit_q, bit_d;
	logic [7:0]              byte_q, byte_d;
	logic [7:0]              msb_q, msb_d;
	logic [7:0]              txb_q, txb_d;
	logic [AW-1:0]           ptr_q, ptr_d;
	logic [1:0]              bidx_q, bidx_d;
	logic                    gc_q, gc_d;
	logic                    rw_q, rw_d;
	logic                    ack_q, ack_d;
	logic                    lsb_q, lsb_d;
	logic                    sda_n_q, sda_n_d;
	logic [AW-1:0]           ra_q, ra_d;
	logic [FRAME_BITS-1:0]   frame;
	logic                    frame_ok;

	always_comb begin
		proto_d = proto_q;
		shift_d = shift_q;
		first_d = first_q;
		last_d  = last_q;
		mod_d   = mod_q;
		full_d  = full_q;
		sdo_d   = sdo_q;
		wr_d    = 1'b0;
		wa_d    = wa_q;
		wd_d    = wd_q;
		rst_d   = 1'b0;
		ist_d   = ist_q;
		bit_d   = bit_q;
		byte_d  = byte_q;
		msb_d   = msb_q;
		txb_d   = txb_q;
		ptr_d   = ptr_q;
		bidx_d  = bidx_q;
		gc_d    = gc_q;
		rw_d    = rw_q;
		ack_d   = ack_q;
		lsb_d   = lsb_q;
		sda_n_d = sda_n_q;
		ra_d    = (proto_q == DPS_I2C) ? ptr_q : last_q[ADDR_HI:ADDR_LO];
		frame    = SERIAL_OUT_ENABLE ? shift_q : first_q;
		frame_ok = full_q && (!SERIAL_OUT_ENABLE || mod_q == '0);

		// ------------------------------------------------------------
		// spi
		// ------------------------------------------------------------
		if (proto_q != DPS_I2C) begin
			if (fall[P_SYNC]) begin
				proto_d = DPS_SPI;
				// response to the previous validated frame
				shift_d = {last_q[OP_BIT:ADDR_LO],
					last_q[OP_BIT] ? RD_DATA : last_q[DATA_HI:0]};
				mod_d   = '0;
				full_d  = 1'b0;
				sdo_d   = shift_d[OP_BIT];
			end else if (!pin_s[P_SYNC]) begin
				if (fall[P_SCLK]) begin
					shift_d = {shift_q[FRAME_BITS-2:0], pin_s[P_SDI]};
					if (mod_q == FRAME_LAST) begin
						mod_d  = '0;
						full_d = 1'b1;
						if (!full_q)
							first_d = shift_d;
					end else begin
						mod_d = mod_q + 5'h1;
					end
					if (!SERIAL_OUT_EDGE_SELECT)
						sdo_d = shift_d[OP_BIT];
				end
				if (rise[P_SCLK] && SERIAL_OUT_EDGE_SELECT)
					sdo_d = shift_q[OP_BIT];
			end else if (rise[P_SYNC] && proto_q == DPS_SPI && frame_ok) begin
				last_d = frame;
				if (frame[OP_BIT] != OP_READ) begin
					wr_d = 1'b1;
					wa_d = frame[ADDR_HI:ADDR_LO];
					wd_d = frame[DATA_HI:0];
				end
			end
		end

		// ------------------------------------------------------------
		// i2c, one protocol at every bus rate
		// ------------------------------------------------------------
		if (proto_q != DPS_SPI) begin
			if (start_c) begin
				proto_d = DPS_I2C;
				ist_d   = I_ADDR;
				bit_d   = '0;
				sda_n_d = 1'b1;
			end else if (stop_c) begin
				ist_d   = I_IDLE;
				sda_n_d = 1'b1;
			end else begin
				case (ist_q)
					I_ADDR, I_WR: begin
						if (rise[P_SCL]) begin
							byte_d = {byte_q[BYTE_MSB-1:0], pin_s[P_SDA]};
							bit_d  = bit_q + 4'h1;
						end
						if (fall[P_SCL] && bit_q == ACK_BIT) begin
							bit_d = '0;
							if (ist_q == I_WR) begin
								ist_d   = I_WACK;
								sda_n_d = 1'b0;
							end else if (byte_q[BYTE_MSB:1] == OWN_ADDR
								|| byte_q == GC_ADDR) begin
								ist_d   = I_AACK;
								sda_n_d = 1'b0;
								gc_d    = (byte_q == GC_ADDR);
								rw_d    = byte_q[0];
								bidx_d  = IDX_CMD;
							end else begin
								ist_d = I_IDLE;
							end
						end
					end
					I_AACK: begin
						if (fall[P_SCL]) begin
							if (rw_q) begin
								ist_d   = I_RD;
								txb_d   = RD_DATA[DATA_HI:DATA_HI-BYTE_MSB];
								lsb_d   = 1'b0;
								sda_n_d = txb_d[BYTE_MSB];
							end else begin
								ist_d   = I_WR;
								sda_n_d = 1'b1;
							end
						end
					end
					I_WACK: begin
						if (rise[P_SCL] && gc_q && bidx_q == IDX_CMD && byte_q == GC_RESET)
							rst_d = 1'b1;
						if (fall[P_SCL]) begin
							ist_d   = I_WR;
							sda_n_d = 1'b1;
							if (!gc_q) begin
								case (bidx_q)
									IDX_CMD: begin
										ptr_d  = byte_q[AW-1:0];
										bidx_d = IDX_MSB;
									end
									IDX_MSB: begin
										msb_d  = byte_q;
										bidx_d = IDX_LSB;
									end
									default: begin
										wr_d   = 1'b1;
										wa_d   = ptr_q;
										wd_d   = {msb_q, byte_q};
										bidx_d = IDX_MSB;
									end
								endcase
							end
						end
					end
					I_RD: begin
						if (rise[P_SCL])
							bit_d = bit_q + 4'h1;
						if (fall[P_SCL]) begin
							if (bit_q == ACK_BIT) begin
								ist_d   = I_RACK;
								bit_d   = '0;
								sda_n_d = 1'b1;
							end else begin
								txb_d   = {txb_q[BYTE_MSB-1:0], 1'b1};
								sda_n_d = txb_d[BYTE_MSB];
							end
						end
					end
					I_RACK: begin
						if (rise[P_SCL])
							ack_d = ~pin_s[P_SDA];
						if (fall[P_SCL]) begin
							if (ack_q) begin
								ist_d   = I_RD;
								lsb_d   = ~lsb_q;
								txb_d   = lsb_q ? RD_DATA[DATA_HI:DATA_HI-BYTE_MSB]
									: RD_DATA[BYTE_MSB:0];
								sda_n_d = txb_d[BYTE_MSB];
							end else begin
								ist_d = I_IDLE;
							end
						end
					end
					default: ist_d = I_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			proto_q <= DPS_NONE;
			shift_q <= '0;
			first_q <= '0;
			last_q  <= '0;
			mod_q   <= '0;
			full_q  <= 1'b0;
			sdo_q   <= 1'b0;
			wr_q    <= 1'b0;
			wa_q    <= '0;
			wd_q    <= '0;
			rst_q   <= 1'b0;
			ist_q   <= I_IDLE;
			bit_q   <= '0;
			byte_q  <= '0;
			msb_q   <= '0;
			txb_q   <= '0;
			ptr_q   <= '0;
			bidx_q  <= IDX_CMD;
			gc_q    <= 1'b0;
			rw_q    <= 1'b0;
			ack_q   <= 1'b0;
			lsb_q   <= 1'b0;
			sda_n_q <= 1'b1;
			ra_q    <= '0;
		end else begin
			proto_q <= proto_d;
			shift_q <= shift_d;
			first_q <= first_d;
			last_q  <= last_d;
			mod_q   <= mod_d;
			full_q  <= full_d;
			sdo_q   <= sdo_d;
			wr_q    <= wr_d;
			wa_q    <= wa_d;
			wd_q    <= wd_d;
			rst_q   <= rst_d;
			ist_q   <= ist_d;
			bit_q   <= bit_d;
			byte_q  <= byte_d;
			msb_q   <= msb_d;
			txb_q   <= txb_d;
			ptr_q   <= ptr_d;
			bidx_q  <= bidx_d;
			gc_q    <= gc_d;
			rw_q    <= rw_d;
			ack_q   <= ack_d;
			lsb_q   <= lsb_d;
			sda_n_q <= sda_n_d;
			ra_q    <= ra_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PINS.sdo_o      = sdo_q;
	assign PINS.sdo_oe_n   = ~(proto_q == DPS_SPI && !pin_s[P_SYNC] && SERIAL_OUT_ENABLE);
	assign PINS.t_sda_o    = 1'b0;
	assign PINS.t_sda_oe_n = sda_n_q;
	assign WR_STB          = wr_q;
	assign WR_ADDR         = wa_q;
	assign WR_DATA         = wd_q;
	assign RD_ADDR         = ra_q;
	assign SOFT_RESET      = rst_q;
	assign PROTOCOL        = proto_q;
endmodule

// >>> verilog/dps_host.sv
/*
 * host end: spi host that frames a bit string, and a byte-level i2c controller.
 * assumes the user sequences frames and i2c commands; scl is never stretched.
 */
`timescale 1ns/1ps
module dps_host #(
	parameter int HALF    = dps_pkg::SCLK_HALF,
	parameter int QUARTER = dps_pkg::I2C_QUARTER,
	parameter int MAXBITS = 48
) (
	input  wire logic               REF_CLK,
	input  wire logic               RST_N,
	dps_if.host                     PINS,
	input  wire logic               SPI_GO,
	input  wire logic [6:0]         SPI_NBITS,
	input  wire logic [MAXBITS-1:0] SPI_TX,
	output logic      [MAXBITS-1:0] SPI_RX,
	output logic                    SPI_BUSY,
	input  wire logic               I2C_GO,
	input  wire dps_pkg::dps_icmd_t I2C_CMD,
	input  wire logic [7:0]         I2C_TX,
	input  wire logic               I2C_ACK_IN,
	output logic      [7:0]         I2C_RX,
	output logic                    I2C_NACK,
	output logic                    I2C_BUSY
);
	import dps_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_LEAD, S_HI, S_LO, S_TAIL} dps_sst_t;
	typedef enum logic [1:0] {H_IDLE, H_RUN} dps_hst_t;

	logic [2:0] pin_s;

	dps_sync #(.W(3)) u_sync (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.d     ({PINS.sdo, PINS.scl, PINS.sda}),
		.q     (pin_s)
	);

	// ----------------------------------------------------------------
	// spi host
	// ----------------------------------------------------------------
	dps_sst_t           sst_q, sst_d;
	logic [11:0]        sdv_q, sdv_d;
	logic [6:0]         scnt_q, scnt_d;
	logic [MAXBITS-1:0] tx_q, tx_d;
	logic [MAXBITS-1:0] rx_q, rx_d;
	logic               syn_q, syn_d;
	logic               sck_q, sck_d;
	logic               sdi_q, sdi_d;
	logic               stick;

	assign stick = (sdv_q == '0);

	always_comb begin
		sst_d  = sst_q;
		sdv_d  = stick ? 12'(HALF - 1) : sdv_q - 12'h1;
		scnt_d = scnt_q;
		tx_d   = tx_q;
		rx_d   = rx_q;
		syn_d  = syn_q;
		sck_d  = sck_q;
		sdi_d  = sdi_q;
		case (sst_q)
			S_IDLE: begin
				sdv_d = 12'(HALF - 1);
				if (SPI_GO) begin
					sst_d  = S_LEAD;
					syn_d  = 1'b0;
					scnt_d = '0;
					tx_d   = SPI_TX;
				end
			end
			S_LEAD, S_LO: begin
				if (stick) begin
					sst_d = S_HI;
					sck_d = 1'b1;
					sdi_d = tx_q[MAXBITS-1];
					tx_d  = {tx_q[MAXBITS-2:0], 1'b0};
				end
			end
			S_HI: begin
				if (stick) begin
					sck_d  = 1'b0;
					rx_d   = {rx_q[MAXBITS-2:0], pin_s[2]};
					scnt_d = scnt_q + 7'h1;
					sst_d  = (scnt_d == SPI_NBITS) ? S_TAIL : S_LO;
				end
			end
			S_TAIL: begin
				if (stick) begin
					syn_d = 1'b1;
					sst_d = S_IDLE;
				end
			end
			default: sst_d = S_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sst_q  <= S_IDLE;
			sdv_q  <= '0;
			scnt_q <= '0;
			tx_q   <= '0;
			rx_q   <= '0;
			syn_q  <= 1'b1;
			sck_q  <= 1'b0;
			sdi_q  <= 1'b0;
		end else begin
			sst_q  <= sst_d;
			sdv_q  <= sdv_d;
			scnt_q <= scnt_d;
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			syn_q  <= syn_d;
			sck_q  <= sck_d;
			sdi_q  <= sdi_d;
		end
	end

	// ----------------------------------------------------------------
	// i2c controller, four quarters per bit
	// ----------------------------------------------------------------
	dps_hst_t    hst_q, hst_d;
	dps_icmd_t   cmd_q, cmd_d;
	logic [11:0] qdv_q, qdv_d;
	logic [1:0]  ph_q, ph_d;
	logic [3:0]  hb_q, hb_d;
	logic [7:0]  sh_q, sh_d;
	logic        nack_q, nack_d;
	logic        ackin_q, ackin_d;
	logic        scl_q, scl_d;
	logic        sda_q, sda_d;
	logic        qtick;

	assign qtick = (qdv_q == '0);

	always_comb begin
		hst_d   = hst_q;
		cmd_d   = cmd_q;
		qdv_d   = qtick ? 12'(QUARTER - 1) : qdv_q - 12'h1;
		ph_d    = ph_q;
		hb_d    = hb_q;
		sh_d    = sh_q;
		nack_d  = nack_q;
		ackin_d = ackin_q;
		scl_d   = scl_q;
		sda_d   = sda_q;
		case (hst_q)
			H_IDLE: begin
				qdv_d = 12'(QUARTER - 1);
				if (I2C_GO) begin
					hst_d   = H_RUN;
					cmd_d   = I2C_CMD;
					ph_d    = '0;
					hb_d    = '0;
					sh_d    = I2C_TX;
					ackin_d = I2C_ACK_IN;
				end
			end
			H_RUN: begin
				if (qtick) begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: begin
							case (cmd_q)
								DPS_START: sda_d = 1'b1;
								DPS_STOP:  sda_d = 1'b0;
								DPS_WRITE: sda_d = (hb_q == ACK_BIT) | sh_q[BYTE_MSB];
								default:   sda_d = (hb_q == ACK_BIT) ? ~ackin_q : 1'b1;
							endcase
						end
						2'h1: scl_d = 1'b1;
						2'h2: begin
							if (cmd_q == DPS_START)
								sda_d = 1'b0;
							else if (cmd_q == DPS_STOP)
								sda_d = 1'b1;
							else if (hb_q == ACK_BIT)
								nack_d = pin_s[0];
							else
								sh_d = {sh_q[BYTE_MSB-1:0], pin_s[0]};
						end
						default: begin
							if (cmd_q == DPS_START || cmd_q == DPS_STOP) begin
								scl_d = (cmd_q == DPS_STOP);
								hst_d = H_IDLE;
							end else begin
								scl_d = 1'b0;
								hb_d  = hb_q + 4'h1;
								if (hb_q == ACK_BIT)
									hst_d = H_IDLE;
							end
						end
					endcase
				end
			end
			default: hst_d = H_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hst_q   <= H_IDLE;
			cmd_q   <= DPS_START;
			qdv_q   <= '0;
			ph_q    <= '0;
			hb_q    <= '0;
			sh_q    <= '0;
			nack_q  <= 1'b0;
			ackin_q <= 1'b0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			hst_q   <= hst_d;
			cmd_q   <= cmd_d;
			qdv_q   <= qdv_d;
			ph_q    <= ph_d;
			hb_q    <= hb_d;
			sh_q    <= sh_d;
			nack_q  <= nack_d;
			ackin_q <= ackin_d;
			scl_q   <= scl_d;
			sda_q   <= sda_d;
		end
	end

	assign PINS.sync_n     = syn_q;
	assign PINS.sclk       = sck_q;
	assign PINS.sdi        = sdi_q;
	assign PINS.scl_o      = 1'b0;
	assign PINS.scl_oe_n   = scl_q;
	assign PINS.h_sda_o    = 1'b0;
	assign PINS.h_sda_oe_n = sda_q;
	assign SPI_RX          = rx_q;
	assign SPI_BUSY        = (sst_q != S_IDLE);
	assign I2C_RX          = sh_q;
	assign I2C_NACK        = nack_q;
	assign I2C_BUSY        = (hst_q != H_IDLE);
endmodule

// >>> tb/dps_monitor.sv
/*
 * checker for the pins between host end and target end, plus target pulses.
 * assumes one REF_CLK domain and the active low RST_N of the bench.
 */
`timescale 1ns/1ps
module dps_monitor (
	input wire logic                REF_CLK,
	input wire logic                RST_N,
	input wire logic                sync_n,
	input wire logic                scl,
	input wire logic                sdo_oe_n,
	input wire logic                t_sda_oe_n,
	input wire logic                WR_STB,
	input wire logic                SOFT_RESET,
	input wire dps_pkg::dps_proto_t PROTOCOL
);
	import dps_pkg::*;
	default clocking mcb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_sdo_released: assert property (sync_n [*5] |-> sdo_oe_n)
		else $error("sdo driven while deselected");
	chk_wr_after_select: assert property (
		WR_STB && PROTOCOL == DPS_SPI |-> $past(sync_n, 3) && !$past(sync_n, 6))
		else $error("spi write not at select release");
	chk_wr_one_pulse: assert property (WR_STB |=> !WR_STB)
		else $error("write strobe longer than one cycle");
	chk_soft_one_pulse: assert property (SOFT_RESET |=> !SOFT_RESET)
		else $error("soft reset longer than one cycle");
	chk_soft_ack_rise: assert property (
		SOFT_RESET |-> PROTOCOL == DPS_I2C && scl && $past(scl, 2))
		else $error("soft reset outside ack clock high");
	chk_proto_locked: assert property (PROTOCOL != DPS_NONE |=> $stable(PROTOCOL))
		else $error("protocol changed after lock");
	chk_spi_sda_free: assert property (PROTOCOL == DPS_SPI |-> t_sda_oe_n)
		else $error("sda driven in spi mode");
	chk_i2c_sdo_free: assert property (PROTOCOL == DPS_I2C |-> sdo_oe_n)
		else $error("sdo driven in i2c mode");
	chk_sda_high_stable: assert property (scl && $past(scl) |-> $stable(t_sda_oe_n))
		else $error("target sda moved while scl high");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	cov_spi_write: cover property (WR_STB && PROTOCOL == DPS_SPI);
	cov_soft_reset: cover property (SOFT_RESET);
	cov_sdo_drive: cover property (!sdo_oe_n);
	cov_i2c_ack: cover property (PROTOCOL == DPS_I2C && !t_sda_oe_n);
endmodule

// >>> tb/dual_protocol_serial_target_tb_top.sv
/*
 * self-checking bench: host end facing target end, register store, write model.
 * assumes the dps_pkg constants and the host and target headers as delivered.
 */
`timescale 1ns/1ps
module dual_protocol_serial_target_tb_top;
	import dps_pkg::*;
	logic        ref_clk;
	logic        rst_n;
	logic        spi_go;
	logic [6:0]  spi_nbits;
	logic [47:0] spi_tx;
	logic [47:0] spi_rx;
	logic        spi_busy;
	logic        i2c_go;
	dps_icmd_t   i2c_cmd;
	logic [7:0]  i2c_tx;
	logic        i2c_ack_in;
	logic [7:0]  i2c_rx;
	logic        i2c_nack;
	logic        i2c_busy;
	logic [6:0]  own_addr;
	logic        soe;
	logic        edge_sel;
	logic        wr_stb;
	logic [6:0]  wr_addr;
	logic [15:0] wr_data;
	logic [6:0]  rd_addr;
	logic [15:0] mem [128];
	logic        soft_reset;
	dps_proto_t  protocol;
	logic [23:0] wire_sh;
	logic [22:0] seen_q [$];
	logic [22:0] exp_q [$];
	int          em [128];
	int          bad_count;
	int          checks;
	int          soft_seen;
	dps_if pins ();
	dps_host dps_host_i (.REF_CLK(ref_clk), .RST_N(rst_n), .PINS(pins), .SPI_GO(spi_go),
		.SPI_NBITS(spi_nbits), .SPI_TX(spi_tx), .SPI_RX(spi_rx), .SPI_BUSY(spi_busy),
		.I2C_GO(i2c_go), .I2C_CMD(i2c_cmd), .I2C_TX(i2c_tx), .I2C_ACK_IN(i2c_ack_in),
		.I2C_RX(i2c_rx), .I2C_NACK(i2c_nack), .I2C_BUSY(i2c_busy));
	dps_target dps_target_i (.REF_CLK(ref_clk), .RST_N(rst_n), .PINS(pins),
		.OWN_ADDR(own_addr), .SERIAL_OUT_ENABLE(soe), .SERIAL_OUT_EDGE_SELECT(edge_sel),
		.WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr),
		.RD_DATA(mem[rd_addr]), .SOFT_RESET(soft_reset), .PROTOCOL(protocol));
	dps_monitor dps_monitor_i (.REF_CLK(ref_clk), .RST_N(rst_n), .sync_n(pins.sync_n),
		.scl(pins.scl), .sdo_oe_n(pins.sdo_oe_n), .t_sda_oe_n(pins.t_sda_oe_n),
		.WR_STB(wr_stb), .SOFT_RESET(soft_reset), .PROTOCOL(protocol));
	// ----------------------------------------
	// register store and wire watch
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (wr_stb === 1'b1) begin
			mem[wr_addr] <= wr_data;
			seen_q.push_back({wr_addr, wr_data});
		end
		if (soft_reset === 1'b1)
			soft_seen++;
	end
	always @(negedge pins.sclk)
		if (pins.sync_n === 1'b0)
			wire_sh <= {wire_sh[22:0], pins.sdi};
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_idle(input logic i2c_side);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (((i2c_side ? i2c_busy : spi_busy) !== 1'b0) && n < 20000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			bad_count++;
			end_sim();
		end
	endtask
	task automatic spi(input int nbits, input logic [47:0] tx);
		spi_nbits = 7'(nbits);
		spi_tx = tx;
		spi_go = 1'b1;
		@(negedge ref_clk);
		spi_go = 1'b0;
		wait_idle(1'b0);
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic i2c(input dps_icmd_t c, input logic [7:0] b);
		i2c_cmd = c;
		i2c_tx = b;
		i2c_go = 1'b1;
		@(negedge ref_clk);
		i2c_go = 1'b0;
		wait_idle(1'b1);
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic expect_wr(input logic [6:0] a, input logic [15:0] d);
		exp_q.push_back({a, d});
		em[a] = d;
	endtask
	task automatic cmp_q();
		check(seen_q.size(), exp_q.size());
		while (seen_q.size() > 0 && exp_q.size() > 0)
			check(seen_q.pop_front(), exp_q.pop_front());
		seen_q.delete();
		exp_q.delete();
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [6:0]  a;
		logic [15:0] d;
		logic [23:0] f;
		int          lens [3];
		logic [6:0]  bad_addr [2];
		lens = '{24, 23, 30};
		bad_addr = '{7'h2b, 7'h78};
		rst_n = 1'b0;
		{spi_go, spi_nbits, spi_tx, i2c_go, i2c_tx, i2c_ack_in} = '0;
		i2c_cmd = DPS_START;
		own_addr = 7'h2a;
		{soe, edge_sel} = '0;
		{bad_count, checks, soft_seen} = '0;
		void'($urandom(32'hd01c));
		do_reset();
		for (int k = 0; k < 3; k++) begin
			a = 7'($urandom);
			d = 16'($urandom);
			spi(lens[k], {1'b0, a, d, 24'($urandom)});
			if (k == 0)
				check(wire_sh, {1'b0, a, d});
			if (k != 1)
				expect_wr(a, d);
		end
		cmp_q();
		$display("three-wire test done");
		soe = 1'b1;
		for (int es = 0; es < 2; es++) begin
			edge_sel = es[0];
			a = 7'($urandom);
			d = 16'($urandom);
			spi(24, {1'b0, a, d, 24'h0});
			expect_wr(a, d);
			spi(24, {1'b1, a, 16'($urandom), 24'h0});
			check(spi_rx[23:0], {1'b0, a, d});
			spi(24, {1'b1, a, 16'($urandom), 24'h0});
			check(spi_rx[23:0], {1'b1, a, 16'(em[a])});
		end
		f = {1'b0, 7'($urandom), 16'($urandom)};
		a = 7'($urandom);
		d = 16'($urandom);
		spi(48, {f, 1'b0, a, d});
		expect_wr(a, d);
		check(spi_rx[23:0], f);
		spi(30, {1'b0, a, ~d, 24'h0});
		cmp_q();
		check(protocol, DPS_SPI);
		$display("four-wire test done");
		do_reset();
		a = 7'($urandom);
		d = 16'($urandom);
		i2c(DPS_START, 8'h0);
		i2c(DPS_WRITE, {own_addr, 1'b0});
		check(i2c_nack, 1'b0);
		for (int b = 0; b < 3; b++) begin
			i2c(DPS_WRITE, (b == 0) ? {1'b0, a} : (b == 1) ? d[15:8] : d[7:0]);
			check(i2c_nack, 1'b0);
		end
		i2c(DPS_STOP, 8'h0);
		expect_wr(a, d);
		check({pins.scl, pins.sda}, 2'h3);
		cmp_q();
		i2c(DPS_START, 8'h0);
		i2c(DPS_WRITE, {own_addr, 1'b1});
		i2c_ack_in = 1'b1;
		i2c(DPS_READ, 8'h0);
		check(i2c_rx, em[a][15:8]);
		i2c_ack_in = 1'b0;
		i2c(DPS_READ, 8'h0);
		check(i2c_rx, em[a][7:0]);
		i2c(DPS_STOP, 8'h0);
		for (int k = 0; k < 2; k++) begin
			i2c(DPS_START, 8'h0);
			i2c(DPS_WRITE, {bad_addr[k], 1'b0});
			check(i2c_nack, 1'b1);
			i2c(DPS_WRITE, 8'h5a);
			check(i2c_nack, 1'b1);
			i2c(DPS_STOP, 8'h0);
		end
		i2c(DPS_START, 8'h0);
		i2c(DPS_WRITE, GC_ADDR);
		check(i2c_nack, 1'b0);
		i2c(DPS_WRITE, GC_RESET);
		i2c(DPS_STOP, 8'h0);
		check(soft_seen, 1);
		$display("i2c test done");
		spi(24, {1'b0, a, ~d, 24'h0});
		cmp_q();
		check(protocol, DPS_I2C);
		$display("lock test done");
		end_sim();
	end
endmodule
